/* File: design/program_fetch_vector_logic.sv */
// program counter, vectors and flash fetch path
// assumes flash answers combinationally on a separate program bus
// the word on INSTR was read at the previous FETCH_ADDR
`timescale 1ns/100ps
`default_nettype none
module program_fetch_vector_logic #(
    parameter int FLASH_BYTES = fetch_pkg::FLASH_LARGE_BYTES
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic CE,
    // core control
    input wire logic ADVANCE,
    input wire logic WAKE_IRQ,
    input wire logic HIGH_PRIO_REQ,
    input wire logic LOW_PRIO_REQ,
    input wire logic GLOBAL_HIGH_PRIO_ENABLE,
    input wire logic GLOBAL_LOW_PRIO_ENABLE,
    // program bus
    output logic [20:0] FETCH_ADDR,
    input wire logic [15:0] FLASH_RDATA,
    output logic [15:0] INSTR,
    // stack view
    output logic [20:0] STACK_TOP,
    output logic [4:0] RETURN_STACK_POINTER,
    output logic STACK_FULL,
    // wake-up cause flags
    output logic [7:0] WAKE_FLAGS
);
    typedef enum logic [1:0] {RUN, VECTOR} state_e;
    state_e st_q, st_d;
    logic [20:0] pc_q, pc_d;
    logic [15:0] instr_d;
    logic [7:0] flags_q, flags_d;
    logic take_hi, take_lo, push;
    logic [20:0] top_w;
    logic [4:0] sp_w;
    logic full_w;

    localparam logic [20:0] FLASH_END = 21'(FLASH_BYTES);

    // --------------------------------------------------------------------
    // vectoring and counter
    // --------------------------------------------------------------------
    always_comb begin
        take_hi = WAKE_IRQ && HIGH_PRIO_REQ && GLOBAL_HIGH_PRIO_ENABLE;
        take_lo = WAKE_IRQ && LOW_PRIO_REQ && GLOBAL_LOW_PRIO_ENABLE && !take_hi;
        push = take_hi || take_lo;
        pc_d = pc_q;
        st_d = st_q;
        flags_d = flags_q;
        if (WAKE_IRQ) begin
            flags_d = flags_q | {6'h00, LOW_PRIO_REQ, HIGH_PRIO_REQ};
        end
        case (st_q)
            RUN: begin
                if (take_hi) begin
                    pc_d = fetch_pkg::HIGH_VEC;
                    st_d = VECTOR;
                end else if (take_lo) begin
                    pc_d = fetch_pkg::LOW_VEC;
                    st_d = VECTOR;
                end else if (ADVANCE) begin
                    pc_d = pc_q + fetch_pkg::PC_STEP;
                end
            end
            VECTOR: begin
                st_d = RUN;
            end
            default: st_d = RUN;
        endcase
        pc_d[0] = 1'b0;
        // beyond implemented flash reads as a no-op
        // judged by the address the flash sees now, not the one being formed
        instr_d = (pc_q < FLASH_END) ? FLASH_RDATA : fetch_pkg::NOP_WORD;
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            pc_q <= fetch_pkg::RESET_VEC;
            st_q <= RUN;
            flags_q <= 8'h00;
        end else if (CE) begin
            pc_q <= pc_d;
            st_q <= st_d;
            flags_q <= flags_d;
        end
    end

    // --------------------------------------------------------------------
    // stack
    // --------------------------------------------------------------------
    return_stack u_stack (
        .clk(REF_CLK),
        .srst(SRST),
        .ce(CE),
        .push(push && st_q == RUN),
        .push_data(pc_q),
        .top_q(top_w),
        .sp_q(sp_w),
        .full_q(full_w)
    );

    // --------------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            FETCH_ADDR <= fetch_pkg::RESET_VEC;
            INSTR <= fetch_pkg::NOP_WORD;
            STACK_TOP <= 21'h00_0000;
            RETURN_STACK_POINTER <= fetch_pkg::SP_RESET;
            STACK_FULL <= 1'b0;
            WAKE_FLAGS <= 8'h00;
        end else if (CE) begin
            FETCH_ADDR <= pc_d;
            INSTR <= instr_d;
            STACK_TOP <= top_w;
            RETURN_STACK_POINTER <= sp_w;
            STACK_FULL <= full_w;
            WAKE_FLAGS <= flags_d;
        end
    end

    // --------------------------------------------------------------------
    // checks
    // --------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    // a high-priority wake taken from the run state
    sequence s_hi_wake;
        CE && st_q == RUN && take_hi;
    endsequence

    // a low-priority wake taken from the run state
    sequence s_lo_wake;
        CE && st_q == RUN && take_lo;
    endsequence

    // a taken wake while the stack still has room
    sequence s_push_room;
        CE && st_q == RUN && push && sp_w != fetch_pkg::SP_MAX;
    endsequence

    // a taken wake once the stack is full
    sequence s_push_full;
        CE && st_q == RUN && push && sp_w == fetch_pkg::SP_MAX;
    endsequence

    // the idle cycle after every wake vector, not after the reset vector
    sequence s_vector_idle;
        CE && st_q == VECTOR;
    endsequence

    // a wake that no global enable lets through
    sequence s_wake_masked;
        CE && st_q == RUN && WAKE_IRQ
            && !(HIGH_PRIO_REQ && GLOBAL_HIGH_PRIO_ENABLE)
            && !(LOW_PRIO_REQ && GLOBAL_LOW_PRIO_ENABLE);
    endsequence

    // counter and vectors
    AST_PC_EVEN: assert property (pc_q[0] == 1'b0)
        else $error("pc odd");
    AST_RESET_VEC: assert property ($fell(SRST) |-> pc_q == fetch_pkg::RESET_VEC)
        else $error("reset vector");
    AST_HI_VEC: assert property (s_hi_wake |=> pc_q == fetch_pkg::HIGH_VEC)
        else $error("high vector");
    AST_LO_VEC: assert property (s_lo_wake |=> pc_q == fetch_pkg::LOW_VEC)
        else $error("low vector");
    AST_HI_WINS: assert property (
        (s_hi_wake and (LOW_PRIO_REQ && GLOBAL_LOW_PRIO_ENABLE)) |=> pc_q == fetch_pkg::HIGH_VEC)
        else $error("priority");
    AST_STEP: assert property (CE && st_q == RUN && ADVANCE && !push |=>
        pc_q == $past(pc_q) + fetch_pkg::PC_STEP)
        else $error("step");
    AST_VECTOR_IDLE: assert property (s_vector_idle |=>
        pc_q == $past(pc_q) && sp_w == $past(sp_w))
        else $error("vector idle");
    AST_MASKED_PC: assert property ((s_wake_masked and !ADVANCE) |=>
        pc_q == $past(pc_q))
        else $error("masked wake vectored");

    // stack
    AST_PUSH_SP: assert property ((s_hi_wake and sp_w != 5'h1f) |=>
        sp_w == $past(sp_w) + 5'h01)
        else $error("push pointer");
    AST_PUSH_TOS: assert property ((s_hi_wake and sp_w != 5'h1f) |=>
        top_w == $past(pc_q))
        else $error("push top");
    AST_PUSH_VIEW: assert property (s_push_room ##1 s_vector_idle |=>
        STACK_TOP == $past(pc_q, 2) && RETURN_STACK_POINTER == $past(sp_w, 2) + 5'h01)
        else $error("stack view");
    AST_PUSH_REFUSED: assert property (s_push_full |=>
        sp_w == fetch_pkg::SP_MAX && full_w)
        else $error("push past full");
    AST_MASKED_WAKE: assert property (s_wake_masked |=> sp_w == $past(sp_w))
        else $error("masked wake pushed");
    AST_FULL_FLAG: assert property (sp_w == fetch_pkg::SP_MAX |-> full_w)
        else $error("full flag");
    AST_RESET_SP: assert property ($fell(SRST) |->
        sp_w == fetch_pkg::SP_RESET && !full_w)
        else $error("stack reset");

    // fetch data
    AST_NOP: assert property (CE && pc_q >= FLASH_END |=>
        INSTR == fetch_pkg::NOP_WORD)
        else $error("nop fill");
    AST_FLASH_WORD: assert property (CE && pc_q < FLASH_END |=>
        INSTR == $past(FLASH_RDATA))
        else $error("flash word");

    // wake flags
    AST_FLAGS: assert property (CE && WAKE_IRQ && HIGH_PRIO_REQ |=> WAKE_FLAGS[0])
        else $error("wake flag");
    AST_FLAGS_LO: assert property (CE && WAKE_IRQ && LOW_PRIO_REQ |=> WAKE_FLAGS[1])
        else $error("low wake flag");
    AST_FLAGS_STICKY: assert property (WAKE_FLAGS != 8'h00 |=>
        (WAKE_FLAGS & $past(WAKE_FLAGS)) == $past(WAKE_FLAGS))
        else $error("flag lost");

    // clock enable
    AST_FREEZE: assert property (!CE |=>
        $stable(pc_q) && $stable(sp_w) && $stable(WAKE_FLAGS))
        else $error("frozen state moved");
endmodule // program_fetch_vector_logic
`default_nettype wire

/* File: design/fetch_pkg.sv */
// constants for the program fetch and vector logic
// assumes a single core clock and a synchronous reset
`default_nettype none
package fetch_pkg;
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int STACK_DEPTH = 31;
    localparam int FLAG_W = 8;
    localparam logic [20:0] RESET_VEC = 21'h00_0000;
    localparam logic [20:0] HIGH_VEC = 21'h00_0008;
    localparam logic [20:0] LOW_VEC = 21'h00_0018;
    localparam logic [20:0] PC_STEP = 21'h00_0002;
    localparam logic [4:0] SP_RESET = 5'h00;
    localparam logic [4:0] SP_MAX = 5'h1f;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    localparam int FLASH_SMALL_BYTES = 24576;
    localparam int FLASH_LARGE_BYTES = 32768;
endpackage
`default_nettype wire

/* File: design/return_stack.sv */
// return address stack: 31 entries of 21 bits, 5-bit pointer
// assumes push is a one-cycle request on the core clock
`timescale 1ns/100ps
`default_nettype none
module return_stack #(
    parameter int DEPTH = fetch_pkg::STACK_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic push,
    input wire logic [20:0] push_data,
    output logic [20:0] top_q,
    output logic [4:0] sp_q,
    output logic full_q
);
    logic [20:0] mem_q [1:DEPTH];
    logic [20:0] mem_d [1:DEPTH];
    logic [4:0] sp_d;
    logic [4:0] sp_nxt;
    logic full_d;

    always_comb begin
        sp_d = sp_q;
        full_d = full_q;
        sp_nxt = sp_q + 5'h01;
        for (int i = 1; i <= DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        // pointer first, then write the entry it selects
        if (push && sp_q != fetch_pkg::SP_MAX) begin
            sp_d = sp_nxt;
            mem_d[sp_nxt] = push_data;
            if (sp_nxt == fetch_pkg::SP_MAX) begin
                full_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sp_q <= fetch_pkg::SP_RESET;
            full_q <= 1'b0;
        end else if (ce) begin
            sp_q <= sp_d;
            full_q <= full_d;
        end
    end

    genvar g;
    generate
        for (g = 1; g <= DEPTH; g++) begin : g_ent
            always_ff @(posedge clk) begin
                if (srst) begin
                    mem_q[g] <= '0;
                end else if (ce) begin
                    mem_q[g] <= mem_d[g];
                end
            end
        end
    endgenerate

    always_comb begin
        top_q = (sp_q == fetch_pkg::SP_RESET) ? 21'h00_0000 : mem_q[sp_q];
    end
endmodule // return_stack
`default_nettype wire

/* File: test/flash_model.sv */
// behavioural flash array on the program bus
// assumes the fetch logic reads it combinationally
`timescale 1ns/100ps
`default_nettype none
module flash_model (
    // program bus
    input wire logic [20:0] addr,
    output logic [15:0] rdata
);
    // never zero, so a zero instruction can only come from the fetch logic
    assign rdata = {addr[15:1], 1'b1};
endmodule // flash_model
`default_nettype wire

/* File: test/program_fetch_vector_logic_bench.sv */
// self-checking bench for the program fetch and vector logic
// assumes a flash model on the program bus and a small flash size
`timescale 1ns/100ps
`default_nettype none
module program_fetch_vector_logic_bench;
    localparam int FB = 64;
    logic ref_clk = 0, srst = 1, ce = 1, advance = 0, wake_irq = 0;
    logic hp = 0, lp = 0, gh = 0, gl = 0, full;
    logic [20:0] fetch_addr, stack_top;
    logic [15:0] flash_rdata, instr;
    logic [4:0] sp;
    logic [7:0] flags;
    int n_errors = 0, n_checks = 0;
    always #5 ref_clk = ~ref_clk;
    program_fetch_vector_logic #(.FLASH_BYTES(FB)) dut_u (.REF_CLK(ref_clk), .SRST(srst),
        .CE(ce), .ADVANCE(advance), .WAKE_IRQ(wake_irq), .HIGH_PRIO_REQ(hp),
        .LOW_PRIO_REQ(lp), .GLOBAL_HIGH_PRIO_ENABLE(gh), .GLOBAL_LOW_PRIO_ENABLE(gl),
        .FETCH_ADDR(fetch_addr), .FLASH_RDATA(flash_rdata), .INSTR(instr),
        .STACK_TOP(stack_top), .RETURN_STACK_POINTER(sp), .STACK_FULL(full),
        .WAKE_FLAGS(flags));
    flash_model flash_u (.addr(fetch_addr), .rdata(flash_rdata));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // hold {advance,wake,hp,lp,gh,gl} for n taking edges
    task automatic drive(input logic [5:0] v, input int n);
        @(posedge ref_clk);
        {advance, wake_irq, hp, lp, gh, gl} <= v;
        repeat (n - 1) @(posedge ref_clk);
        @(posedge ref_clk);
        {advance, wake_irq, hp, lp, gh, gl} <= 6'h00;
        #1;
    endtask
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic results;
        $display("errors=%0d checks=%0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk(fetch_addr, fetch_pkg::RESET_VEC);
        chk(21'(sp), 21'h00_0000);
        chk(21'(flags), 21'h00_0000);
        chk(21'(full), 21'h00_0000);
        chk(stack_top, 21'h00_0000);
    endtask
    task automatic t_seq;
        drive(6'h20, 3);
        chk(fetch_addr, 21'h00_0006);
        chk(21'(instr), 21'h00_0005);
        @(posedge ref_clk);
        ce <= 1'b0;
        advance <= 1'b1;
        @(posedge ref_clk);
        ce <= 1'b1;
        advance <= 1'b0;
        #1;
        chk(fetch_addr, 21'h00_0006);
        drive(6'h20, FB / 2 - 3);
        chk(fetch_addr, 21'(FB));
        chk(21'(instr), 21'h00_003f);
        tick();
        chk(21'(instr), 21'h00_0000);
    endtask
    task automatic t_wake;
        drive(6'h3a, 2);
        chk(fetch_addr, fetch_pkg::HIGH_VEC);
        chk(21'(flags), 21'h00_0001);
        tick();
        chk(21'(sp), 21'h00_0001);
        chk(stack_top, 21'(FB));
        drive(6'h15, 1);
        chk(fetch_addr, fetch_pkg::LOW_VEC);
        chk(21'(flags), 21'h00_0003);
        tick();
        chk(21'(sp), 21'h00_0002);
        chk(stack_top, fetch_pkg::HIGH_VEC);
        drive(6'h1c, 1);
        chk(fetch_addr, fetch_pkg::LOW_VEC);
        tick();
        chk(21'(sp), 21'h00_0002);
    endtask
    task automatic t_full;
        repeat (29) drive(6'h1f, 1);
        tick();
        chk(21'(sp), 21'h00_001f);
        chk(21'(full), 21'h00_0001);
        drive(6'h1a, 1);
        tick();
        chk(21'(sp), 21'h00_001f);
        @(posedge ref_clk);
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        t_reset();
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        t_reset();
        t_seq();
        t_wake();
        t_full();
        results();
    end
    initial begin
        #100000;
        n_errors++;
        results();
    end
endmodule // program_fetch_vector_logic_bench
`default_nettype wire
